/* logic/lbts_pkg.sv */
package lbts_pkg;

	// Geometry of the shaper.
	localparam int NPORT = 12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BYTES_W = 5;
	localparam int PORT_W = 5;

	// Register offsets.
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_PRIORITY = 8'h01;
	localparam logic [7:0] OFS_TIMER = 8'h02;
	localparam logic [7:0] OFS_CLEAR = 8'h03;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_BUCKET_BASE = 8'h20;
	localparam logic [7:0] OFS_COMMON_BUCKET = 8'h38;

	// Field positions.
	localparam int CTRL_ADJ_LSB = 26;
	localparam int CTRL_FAIR_BIT = 25;
	localparam int CTRL_STOP_LSB = 23;
	localparam int CTRL_RSVD_BIT = 22;
	localparam int CTRL_EE_BIT = 21;
	localparam int CTRL_IE_BIT = 20;
	localparam int CTRL_POFS_LSB = 15;
	localparam int CTRL_LOWONLY_BIT = 12;
	localparam int CTRL_PREFILL_BIT = 11;
	localparam int TIMER_EN_BIT = 31;
	localparam int CLEAR_COMMON_BIT = 24;
	localparam int STATUS_COMMON_BIT = 24;
	localparam int BKT_LEVEL_LSB = 16;

	// Values after reset.
	localparam logic [5:0] RST_PORT_ADJ = 6'h14;
	localparam logic [5:0] RST_COMMON_ADJ = 6'h00;
	localparam logic RST_RSVD = 1'h1;
	localparam logic RST_LOWONLY = 1'h1;
	localparam logic [11:0] RST_PRIORITY = 12'h000;
	localparam logic [11:0] RST_CLEAR = 12'hFFF;
	localparam logic RST_CLEAR_COMMON = 1'h1;
	localparam logic [15:0] RST_LEVEL = 16'h7FFF;
	localparam logic [15:0] RST_RATE = 16'hFFFF;

	// Counting constants.
	localparam logic [4:0] ADJ_AFTER_BYTES = 5'h10;
	localparam int LEVEL_UNIT_SHIFT = 7;
	localparam int DRAIN_FRAC = 13;
	localparam int PORT_RATE_SHIFT = 0;
	localparam int COMMON_RATE_SHIFT = 1;

	typedef enum logic [1:0] {
		LBTS_STOP_INDIRECT = 2'h0,
		LBTS_STOP_PER_PORT = 2'h1,
		LBTS_STOP_ALL = 2'h2,
		LBTS_STOP_BAD = 2'h3
	} lbts_stop_t;

endpackage

/* logic/lbts_bucket.sv */
`timescale 1ns/1ps
module lbts_bucket #(
	parameter int FRAC = lbts_pkg::DRAIN_FRAC,
	parameter int RATE_SHIFT = lbts_pkg::PORT_RATE_SHIFT
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Settings.
	input wire logic clear_in,
	input wire logic prefill_in,
	input wire logic [15:0] threshold_in,
	input wire logic [15:0] rate_in,
	// Byte arrivals.
	input wire logic add_valid_in,
	input wire logic [6:0] add_bytes_in,
	// State.
	output logic over_out,
	output logic busy_out
);
	localparam int LW = 24 + FRAC;

	// Refuse settings that the level arithmetic cannot hold.
	if (FRAC < 1 || RATE_SHIFT < 0 || RATE_SHIFT > FRAC)
	begin : g_bad_setting
		$error("lbts_bucket: unsupported fraction or rate shift");
	end

	logic [LW-1:0] level;
	logic held;
	wire [LW-1:0] thr_level = LW'({threshold_in, 7'h00}) << FRAC;
	wire [LW-1:0] drain = LW'(rate_in) << RATE_SHIFT;
	wire [LW-1:0] gain = LW'(add_bytes_in) << FRAC;
	wire [LW-1:0] drained = (held || level < drain) ? (held ? level : '0) : level - drain;
	wire [LW:0] sum = {1'b0, drained} + {1'b0, (add_valid_in ? gain : LW'(0))};
	wire [LW-1:0] next_level = sum[LW] ? {LW{1'b1}} : sum[LW-1:0];

	// A cleared bucket either empties or prefills and waits for data before leaking.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			level <= '0;
			held <= 1'b0;
		end
		else if (ce_in)
		begin
			if (clear_in)
			begin
				level <= prefill_in ? thr_level : '0; // RULE_13
				held <= prefill_in; // RULE_13
			end
			else
			begin
				level <= next_level; // RULE_24
				held <= held && !add_valid_in; // RULE_13
			end
		end
	end

	assign over_out = !clear_in && level >= thr_level; // RULE_22
	assign busy_out = level != '0;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_prefill_hold: assert property (ce_in && held && !clear_in && !add_valid_in |=> // RULE_13
		level == $past(level))
		else $error("prefilled bucket leaked before first data");
	a_drain_floor: assert property (ce_in && !clear_in && !held && !add_valid_in // RULE_24
		&& level >= drain |=> level == $past(level) - $past(drain))
		else $error("bucket did not drain by its rate");
	a_clear_empty: assert property (ce_in && clear_in && !prefill_in |=> level == '0) // RULE_20
		else $error("cleared bucket not empty");
	c_prefill_seen: cover property (ce_in && held && add_valid_in);

endmodule // lbts_bucket

/* logic/lbts_shaper.sv */
// Functional notes
// RULE_01: One bucket per port buffer plus one shared bucket; instantiate once per direction.
// RULE_02: Per-port 6-bit adjustment is added once after first 16 frame bytes.
// RULE_03: Counted length includes any preamble or normalized header delivered.
// RULE_04: Shared bucket has its own 6-bit adjustment, reset zero.
// RULE_05: Fairness bit 25 enables fair bandwidth sharing under host-link limits.
// RULE_06: Software sets port shapers to wire speed, shared rate 0xAD5E.
// RULE_07: Shared-stop selector: 0 indirect, 1 per port, 2 all, 3 illegal.
// RULE_08: Software clears reserved bit 22 before using the shapers.
// RULE_09: Bit 21 clears the link-level enable at end of frame.
// RULE_10: Bit 20 applies per-port inhibits only at frame ends in burst mode.
// RULE_11: Software sets port offset to twelve for egress, zero for ingress.
// RULE_12: Bit 12 set makes shared bucket count only low-priority ports.
// RULE_13: Prefill loads threshold on clear and holds it until first data.
// RULE_14: Software sets prefill before releasing the bucket clear bits.
// RULE_15: High-priority buckets ignore flow control from the shared bucket.
// RULE_16: Software keeps high-priority bandwidth below the shared bucket rate.
// RULE_17: With timer enabled, ports stop while timer value equals zero.
// RULE_18: Enabled timer decrements by one every system clock cycle.
// RULE_19: Timer stops low-priority ports for a set time; readable and writable.
// RULE_20: Twelve clear bits, reset set, clear and disable per-port buckets.
// RULE_21: Bit 24 of clear register clears and disables the shared bucket.
// RULE_22: Each bucket has a 16-bit threshold in 128-byte units.
// RULE_23: Port bucket drains at rate setting times 146484.375 bit/s.
// RULE_24: Level rises by adjusted frame bytes, drains by rate, floors at zero.
`timescale 1ns/1ps
module lbts_shaper #(
	parameter int NPORT = lbts_pkg::NPORT
) (
	// Clock, reset and enable.
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Register port.
	input wire logic [lbts_pkg::ADDR_W-1:0] addr_in,
	input wire logic [lbts_pkg::DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [lbts_pkg::DATA_W-1:0] rdata_out,
	// Frame bytes leaving the FIFO buffers.
	input wire logic fifo_valid_in,
	input wire logic [lbts_pkg::PORT_W-1:0] fifo_port_in,
	input wire logic [lbts_pkg::BYTES_W-1:0] fifo_bytes_in,
	input wire logic fifo_sof_in,
	input wire logic fifo_eof_in,
	input wire logic burst_mode_in,
	// Flow control towards the FIFO core.
	output logic [NPORT-1:0] port_stop_out,
	output logic link_en_clear_out
);
	if (NPORT < 1 || NPORT > 12)
	begin : g_bad_nport
		$error("lbts_shaper: port count must be 1 to 12");
	end


	// Software state.
	logic [5:0] port_adj;
	logic fair_en;
	lbts_pkg::lbts_stop_t stop_mode;
	logic rsvd_bit;
	logic ee_bit;
	logic ie_bit;
	logic [4:0] port_ofs;
	logic low_only;
	logic prefill;
	logic [5:0] common_adj;
	logic [NPORT-1:0] bucket_urgent_select;
	logic timer_en;
	logic [30:0] timer_val;
	logic [NPORT-1:0] clr;
	logic clr_common;
	logic [15:0] bkt_level [NPORT+1];
	logic [15:0] bkt_rate [NPORT+1];

	// Per-port frame tracking.
	logic [4:0] seen [NPORT];
	logic [NPORT-1:0] in_frame;
	logic [3:0] last_port;

	// Register decode.
	function automatic logic hit_at(input logic [7:0] a, input logic [7:0] ofs);
		hit_at = a == ofs;
	endfunction

	wire wr_ctrl = wr_in && hit_at(addr_in, lbts_pkg::OFS_CONTROL);
	wire wr_bucket_urgent_select = wr_in && hit_at(addr_in, lbts_pkg::OFS_PRIORITY);
	wire wr_timer = wr_in && hit_at(addr_in, lbts_pkg::OFS_TIMER);
	wire wr_clear = wr_in && hit_at(addr_in, lbts_pkg::OFS_CLEAR);
	wire [7:0] bkt_rel = addr_in - lbts_pkg::OFS_BUCKET_BASE;
	wire bkt_port_hit = addr_in >= lbts_pkg::OFS_BUCKET_BASE && bkt_rel < 8'(NPORT);
	wire bkt_common_hit = hit_at(addr_in, lbts_pkg::OFS_COMMON_BUCKET);
	wire [3:0] bkt_sel = bkt_common_hit ? 4'(NPORT) : bkt_rel[3:0];
	wire bkt_hit = bkt_port_hit || bkt_common_hit;

	// Incoming byte classification.
	wire [4:0] rel_port = fifo_port_in - port_ofs;
	wire port_ok = rel_port < 5'(NPORT);
	wire hit = fifo_valid_in && port_ok;
	wire [3:0] idx = rel_port[3:0];
	wire [4:0] seen_before = fifo_sof_in ? 5'h00 : seen[idx];
	wire [5:0] seen_sum = {1'b0, seen_before} + {1'b0, fifo_bytes_in};
	wire crossed = seen_before < lbts_pkg::ADJ_AFTER_BYTES
		&& seen_sum >= {1'b0, lbts_pkg::ADJ_AFTER_BYTES};
	wire [4:0] seen_next = seen_sum > {1'b0, lbts_pkg::ADJ_AFTER_BYTES}
		? lbts_pkg::ADJ_AFTER_BYTES : seen_sum[4:0];
	wire [6:0] port_add = {2'h0, fifo_bytes_in} + (crossed ? {1'b0, port_adj} : 7'h00);
	wire [6:0] common_add = {2'h0, fifo_bytes_in} + (crossed ? {1'b0, common_adj} : 7'h00);
	wire common_take = hit && (!low_only || !bucket_urgent_select[idx]);

	// Buckets.
	logic [NPORT:0] over;
	logic [NPORT:0] busy;
	logic [NPORT:0] bkt_clear;
	logic [NPORT:0] bkt_add_valid;
	logic [6:0] bkt_add [NPORT+1];

	genvar g;
	generate
		for (g = 0; g <= NPORT; g++)
		begin : g_bkt
			if (g < NPORT)
			begin : g_port
				assign bkt_clear[g] = clr[g]; // RULE_20
				assign bkt_add_valid[g] = hit && idx == 4'(g); // RULE_03
				assign bkt_add[g] = port_add; // RULE_02
			end
			else
			begin : g_common
				assign bkt_clear[g] = clr_common; // RULE_21
				assign bkt_add_valid[g] = common_take; // RULE_12
				assign bkt_add[g] = common_add; // RULE_04
			end
			lbts_bucket #(
				.FRAC(lbts_pkg::DRAIN_FRAC),
				.RATE_SHIFT(g < NPORT ? lbts_pkg::PORT_RATE_SHIFT : lbts_pkg::COMMON_RATE_SHIFT)
			) u_bucket ( // RULE_01
				.clk_in(clk_in),
				.rstn_in(rstn_in),
				.ce_in(ce_in),
				.clear_in(bkt_clear[g]),
				.prefill_in(prefill),
				.threshold_in(bkt_level[g]), // RULE_22
				.rate_in(bkt_rate[g]), // RULE_23
				.add_valid_in(bkt_add_valid[g]),
				.add_bytes_in(bkt_add[g]),
				.over_out(over[g]),
				.busy_out(busy[g])
			);
		end
	endgenerate

	// Stop decision per port.
	wire c_over = over[NPORT] && !clr_common;
	wire timer_zero = timer_en && timer_val == 31'h00000000;
	logic [NPORT-1:0] own_stop;
	logic [NPORT-1:0] comm_stop;
	logic [NPORT-1:0] want;
	logic [NPORT-1:0] hold_mask;
	logic [NPORT-1:0] next_stop;

	generate
		for (g = 0; g < NPORT; g++)
		begin : g_stop
			assign own_stop[g] = over[g];
			assign comm_stop[g] = c_over && !bucket_urgent_select[g] && ( // RULE_15
				(stop_mode == lbts_pkg::LBTS_STOP_INDIRECT && fair_en && busy[g]) // RULE_05
				|| (stop_mode == lbts_pkg::LBTS_STOP_PER_PORT && last_port == 4'(g)) // RULE_07
				|| stop_mode == lbts_pkg::LBTS_STOP_ALL); // RULE_07
			assign want[g] = !rsvd_bit
				&& (own_stop[g] || comm_stop[g] || (timer_zero && !bucket_urgent_select[g])); // RULE_17
			assign hold_mask[g] = ie_bit && burst_mode_in && in_frame[g]
				&& !(hit && idx == 4'(g) && fifo_eof_in); // RULE_10
			assign next_stop[g] = hold_mask[g] ? port_stop_out[g] : want[g];
		end
	endgenerate

	// Read mux.
	wire [31:0] ctrl_word = {port_adj, fair_en, stop_mode, rsvd_bit, ee_bit, ie_bit, port_ofs,
		2'h0, low_only, prefill, 5'h00, common_adj};
	wire [31:0] bkt_word = {bkt_level[bkt_sel], bkt_rate[bkt_sel]};
	wire [31:0] rd_word =
		hit_at(addr_in, lbts_pkg::OFS_CONTROL) ? ctrl_word :
		hit_at(addr_in, lbts_pkg::OFS_PRIORITY) ? 32'(bucket_urgent_select) :
		hit_at(addr_in, lbts_pkg::OFS_TIMER) ? {timer_en, timer_val} : // RULE_19
		hit_at(addr_in, lbts_pkg::OFS_CLEAR) ? (32'(clr) | (32'(clr_common) << 24)) :
		hit_at(addr_in, lbts_pkg::OFS_STATUS) ? (32'(port_stop_out) | (32'(c_over) << 24)) :
		bkt_hit ? bkt_word : 32'h00000000;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			port_adj <= lbts_pkg::RST_PORT_ADJ;
			fair_en <= 1'b0;
			stop_mode <= lbts_pkg::LBTS_STOP_INDIRECT;
			rsvd_bit <= lbts_pkg::RST_RSVD;
			ee_bit <= 1'b0;
			ie_bit <= 1'b0;
			port_ofs <= 5'h00;
			low_only <= lbts_pkg::RST_LOWONLY;
			prefill <= 1'b0;
			common_adj <= lbts_pkg::RST_COMMON_ADJ;
		end
		else if (ce_in && wr_ctrl)
		begin
			port_adj <= wdata_in[lbts_pkg::CTRL_ADJ_LSB +: 6];
			fair_en <= wdata_in[lbts_pkg::CTRL_FAIR_BIT];
			stop_mode <= lbts_pkg::lbts_stop_t'(wdata_in[lbts_pkg::CTRL_STOP_LSB +: 2]);
			rsvd_bit <= wdata_in[lbts_pkg::CTRL_RSVD_BIT];
			ee_bit <= wdata_in[lbts_pkg::CTRL_EE_BIT];
			ie_bit <= wdata_in[lbts_pkg::CTRL_IE_BIT];
			port_ofs <= wdata_in[lbts_pkg::CTRL_POFS_LSB +: 5];
			low_only <= wdata_in[lbts_pkg::CTRL_LOWONLY_BIT];
			prefill <= wdata_in[lbts_pkg::CTRL_PREFILL_BIT];
			common_adj <= wdata_in[5:0];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			bucket_urgent_select <= NPORT'(lbts_pkg::RST_PRIORITY);
			clr <= NPORT'(lbts_pkg::RST_CLEAR);
			clr_common <= lbts_pkg::RST_CLEAR_COMMON;
		end
		else if (ce_in)
		begin
			if (wr_bucket_urgent_select)
				bucket_urgent_select <= wdata_in[NPORT-1:0];
			if (wr_clear)
			begin
				clr <= wdata_in[NPORT-1:0];
				clr_common <= wdata_in[lbts_pkg::CLEAR_COMMON_BIT];
			end
		end
	end

	// A software write wins over the count so a test can load any value.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			timer_en <= 1'b0;
			timer_val <= 31'h00000000;
		end
		else if (ce_in)
		begin
			if (wr_timer)
			begin
				timer_en <= wdata_in[lbts_pkg::TIMER_EN_BIT];
				timer_val <= wdata_in[30:0]; // RULE_19
			end
			else if (timer_en && timer_val != 31'h00000000)
				timer_val <= timer_val - 31'h00000001; // RULE_18
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (int i = 0; i <= NPORT; i++)
			begin
				bkt_level[i] <= lbts_pkg::RST_LEVEL;
				bkt_rate[i] <= lbts_pkg::RST_RATE;
			end
		end
		else if (ce_in && wr_in && bkt_hit)
		begin
			bkt_level[bkt_sel] <= wdata_in[lbts_pkg::BKT_LEVEL_LSB +: 16];
			bkt_rate[bkt_sel] <= wdata_in[15:0];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			for (int i = 0; i < NPORT; i++)
				seen[i] <= 5'h00;
			in_frame <= '0;
			last_port <= 4'h0;
		end
		else if (ce_in && hit)
		begin
			seen[idx] <= seen_next;
			in_frame[idx] <= !fifo_eof_in;
			last_port <= idx;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			port_stop_out <= '0;
			link_en_clear_out <= 1'b0;
			rdata_out <= 32'h00000000;
		end
		else if (ce_in)
		begin
			port_stop_out <= next_stop;
			link_en_clear_out <= ee_bit && hit && fifo_eof_in && want[idx]; // RULE_09
			rdata_out <= rd_in ? rd_word : 32'h00000000;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	a_timer_counts_down: assert property (ce_in && !wr_timer && timer_en // RULE_18
		&& timer_val != 31'h00000000 |=> timer_val == $past(timer_val) - 31'h00000001)
		else $error("timer did not count down by one");
	a_timer_stops_low: assert property (timer_zero && !rsvd_bit |-> (want & ~bucket_urgent_select) == ~bucket_urgent_select) // RULE_17
		else $error("timer at zero did not stop low-priority ports");
	a_urgent_ignores_shared: assert property (!timer_zero |-> ((want ^ (own_stop & // RULE_15
		{NPORT{!rsvd_bit}})) & bucket_urgent_select) == '0)
		else $error("high-priority port followed the shared bucket");
	a_stop_all_mode: assert property (stop_mode == lbts_pkg::LBTS_STOP_ALL && c_over // RULE_07
		&& !rsvd_bit |-> (want & ~bucket_urgent_select) == ~bucket_urgent_select)
		else $error("shared stop-all did not stop every low-priority port");
	a_adjust_once: assert property (hit && crossed |-> bkt_add[idx] == // RULE_02
		7'(fifo_bytes_in) + 7'(port_adj))
		else $error("per-port adjustment not added at 16 bytes");
	a_shared_low_only: assert property (hit && low_only && bucket_urgent_select[idx] |-> // RULE_12
		!bkt_add_valid[NPORT])
		else $error("shared bucket counted a high-priority port");
	a_eof_link_clear: assert property (ce_in && hit && fifo_eof_in && ee_bit && want[idx] // RULE_09
		|=> link_en_clear_out ##1 (!ce_in || !link_en_clear_out || $past(hit && fifo_eof_in)))
		else $error("link enable clear not pulsed at frame end");
	a_eof_inhibit_hold: assert property (ce_in && hold_mask != '0 |=> // RULE_10
		((port_stop_out ^ $past(port_stop_out)) & $past(hold_mask)) == '0)
		else $error("inhibit changed in mid-frame");
	a_read_timer: assert property (ce_in && rd_in && hit_at(addr_in, lbts_pkg::OFS_TIMER) // RULE_19
		|=> rdata_out == {$past(timer_en), $past(timer_val)})
		else $error("timer read back wrong");

	c_timer_expire: cover property (timer_en && timer_val == 31'h00000001 ##1 timer_zero);
	c_stop_all: cover property (stop_mode == lbts_pkg::LBTS_STOP_ALL && c_over);
	c_link_clear: cover property (link_en_clear_out);
	c_held_inhibit: cover property (hold_mask != '0 && want != port_stop_out);

endmodule // lbts_shaper

/* verification/lbts_fifo_model.sv */
`timescale 1ns/1ps
module lbts_fifo_model (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rstn_in,
	// Frame request from the bench.
	input wire logic start_in,
	input wire logic [4:0] port_in,
	input wire logic [15:0] len_in,
	output logic busy_out,
	// Flow control from the shaper.
	input wire logic [11:0] stop_in,
	// Frame bytes towards the shaper.
	output logic valid_out,
	output logic [4:0] port_out,
	output logic [4:0] bytes_out,
	output logic sof_out,
	output logic eof_out
);
	logic [4:0] port_r;
	logic [15:0] left;
	logic first;
	wire logic [4:0] chunk = (left > 16'h0010) ? 5'h10 : left[4:0];
	wire logic held = first && stop_in[port_r[3:0]];

	// A frame never starts on a stopped port, and idle data lines toggle so nothing stale shows.
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			busy_out <= 1'b0;
			valid_out <= 1'b0;
			port_out <= 5'h00;
			bytes_out <= 5'h00;
			sof_out <= 1'b0;
			eof_out <= 1'b0;
			port_r <= 5'h00;
			left <= 16'h0000;
			first <= 1'b0;
		end
		else
		begin
			valid_out <= 1'b0;
			sof_out <= 1'b0;
			eof_out <= 1'b0;
			port_out <= ~port_out;
			bytes_out <= ~bytes_out;
			if (!busy_out)
			begin
				busy_out <= start_in;
				port_r <= port_in;
				left <= len_in;
				first <= 1'b1;
			end
			else if (left == 16'h0000)
				busy_out <= 1'b0;
			else if (!held)
			begin
				valid_out <= 1'b1;
				port_out <= port_r;
				bytes_out <= chunk;
				sof_out <= first;
				eof_out <= (left <= 16'h0010);
				first <= 1'b0;
				left <= left - {11'h000, chunk};
			end
		end
	end
endmodule // lbts_fifo_model

/* verification/leaky_bucket_traffic_shaper_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("wrong value %s expected %h seen %h", nm, exp, got); \
		end \
	end
module leaky_bucket_traffic_shaper_tb;
	localparam logic [7:0] A_CTL = lbts_pkg::OFS_CONTROL;
	localparam logic [7:0] A_PRI = lbts_pkg::OFS_PRIORITY;
	localparam logic [7:0] A_TMR = lbts_pkg::OFS_TIMER;
	localparam logic [7:0] A_CLR = lbts_pkg::OFS_CLEAR;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic start = 1'b0;
	logic [4:0] sport = 5'h00;
	logic [15:0] slen = 16'h0000;
	logic busy;
	logic valid;
	logic sof;
	logic eof;
	logic lclr;
	logic [4:0] fport;
	logic [4:0] fbytes;
	logic [11:0] stop;
	int n_fail = 0;
	int n_checks = 0;
	int n_link = 0;
	int n_mid = 0;
	logic burst = 1'b0;

	lbts_shaper lbts_shaper_i (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.fifo_valid_in(valid), .fifo_port_in(fport), .fifo_bytes_in(fbytes),
		.fifo_sof_in(sof), .fifo_eof_in(eof), .burst_mode_in(burst),
		.port_stop_out(stop), .link_en_clear_out(lclr));
	lbts_fifo_model lbts_fifo_model_i (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start),
		.port_in(sport), .len_in(slen), .busy_out(busy), .stop_in(stop), .valid_out(valid),
		.port_out(fport), .bytes_out(fbytes), .sof_out(sof), .eof_out(eof));

	initial
		forever #50 clk_in = ~clk_in;

	// Sampled mid-cycle, where outputs and frame bytes have settled.
	always @(negedge clk_in)
	begin
		if (lclr === 1'b1)
			n_link++;
		if (valid === 1'b1 && stop[0] === 1'b1)
			n_mid++;
	end

	task automatic conclude();
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic do_reset();
		@(posedge clk_in);
		rstn_in <= 1'b0;
		repeat (6) @(posedge clk_in);
		rstn_in <= 1'b1;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		reg_rd(a, v);
		`CHK("register read", e, v)
	endtask

	task automatic send(input logic [4:0] p, input logic [15:0] n);
		@(posedge clk_in);
		sport <= p;
		slen <= n;
		start <= 1'b1;
		@(posedge clk_in);
		start <= 1'b0;
		for (int i = 0; i < 400; i++)
		begin
			@(negedge clk_in);
			if (busy === 1'b0)
				return;
		end
		n_fail++;
		conclude();
	endtask

	task automatic s_regs();
		logic [7:0] a[8] = '{A_CTL, A_PRI, A_TMR, A_CLR, 8'h10, 8'h2B, 8'h38, 8'h05};
		logic [31:0] e[8] = '{32'h50401000, 32'h0, 32'h0, 32'h01000FFF, 32'h0,
			32'h7FFFFFFF, 32'h7FFFFFFF, 32'h0};
		do_reset();
		for (int i = 0; i < 8; i++)
			chk_reg(a[i], e[i]);
		`CHK("stop after reset", 12'h000, stop)
		reg_wr(A_PRI, 32'h00000ABC);
		chk_reg(A_PRI, 32'h00000ABC);
		reg_wr(8'h21, 32'h12345678);
		chk_reg(8'h21, 32'h12345678);
		reg_wr(8'h38, 32'h0002AD5E);
		chk_reg(8'h38, 32'h0002AD5E);
		reg_wr(8'h05, 32'hFFFFFFFF);
		chk_reg(8'h05, 32'h0);
	endtask

	task automatic s_timer();
		logic [31:0] t0;
		logic [31:0] t1;
		do_reset();
		reg_wr(A_CTL, 32'h50001000);
		reg_wr(A_PRI, 32'h0000000F);
		reg_wr(A_CLR, 32'h0);
		reg_wr(A_TMR, 32'h80000100);
		reg_rd(A_TMR, t0);
		repeat (8) @(posedge clk_in);
		reg_rd(A_TMR, t1);
		`CHK("timer step", 32'h0000000A, t0 - t1)
		`CHK("timer enable", 1'b1, t1[31])
		`CHK("ports before zero", 12'h000, stop)
		reg_wr(A_TMR, 32'h80000003);
		for (int i = 0; i < 20 && stop !== 12'hFF0; i++)
			@(negedge clk_in);
		`CHK("timer stop", 12'hFF0, stop)
	endtask

	task automatic s_bucket();
		do_reset();
		reg_wr(A_CTL, 32'h50201000);
		reg_wr(8'h20, 32'h00010000);
		reg_wr(A_CLR, 32'h01000000);
		n_link = 0;
		send(5'h00, 16'h0050);
		repeat (3) @(negedge clk_in);
		`CHK("stop below level", 1'b0, stop[0])
		`CHK("no link clear", 32'h0, n_link)
		send(5'h00, 16'h0020);
		repeat (3) @(negedge clk_in);
		`CHK("stop with offset", 1'b1, stop[0])
		`CHK("link clear", 32'h1, n_link)
	endtask

	task automatic s_inhibit();
		do_reset();
		reg_wr(A_CTL, 32'h50101000);
		reg_wr(8'h20, 32'h00010000);
		reg_wr(A_CLR, 32'h01000000);
		burst <= 1'b1;
		n_mid = 0;
		send(5'h00, 16'h0090);
		repeat (3) @(negedge clk_in);
		`CHK("inhibit mid-frame", 32'h0, n_mid)
		`CHK("inhibit at frame end", 1'b1, stop[0])
		reg_wr(A_CLR, 32'h01000001);
		reg_wr(A_CLR, 32'h01000000);
		burst <= 1'b0;
		n_mid = 0;
		send(5'h00, 16'h0090);
		repeat (3) @(negedge clk_in);
		`CHK("stop mid-frame", 32'h1, n_mid)
		`CHK("stop after frame", 1'b1, stop[0])
	endtask

	task automatic s_prefill();
		do_reset();
		reg_wr(A_CTL, 32'h50001800);
		reg_wr(8'h21, 32'h0001FFFF);
		reg_wr(A_CLR, 32'h01000000);
		repeat (40) @(negedge clk_in);
		`CHK("prefill hold", 12'hFFF, stop)
		reg_wr(A_CLR, 32'h01000FFF);
		repeat (3) @(negedge clk_in);
		`CHK("clear disables", 12'h000, stop)
	endtask

	task automatic s_shared();
		logic [11:0] es[5] = '{12'h000, 12'h008, 12'hFFB, 12'h000, 12'h008};
		logic [31:0] st;
		do_reset();
		reg_wr(A_CTL, 32'h51001000);
		reg_wr(A_PRI, 32'h00000004);
		reg_wr(8'h38, 32'h00010000);
		reg_wr(8'h23, 32'h7FFF0000);
		reg_wr(A_CLR, 32'h0);
		send(5'h02, 16'h00A0);
		repeat (3) @(negedge clk_in);
		`CHK("high port not counted", 12'h000, stop)
		send(5'h03, 16'h0080);
		for (int m = 0; m < 5; m++)
		begin
			reg_wr(A_CTL, 32'h50001000 | (32'(m) << 23));
			repeat (3) @(negedge clk_in);
			`CHK("shared stop", es[m], stop)
		end
		reg_rd(8'h10, st);
		`CHK("shared over", 1'b1, st[24])
	endtask

	initial
	begin
		s_regs();
		s_timer();
		s_bucket();
		s_inhibit();
		s_prefill();
		s_shared();
		conclude();
	end
endmodule // leaky_bucket_traffic_shaper_tb
